// ### cpu_event_entry_return.sv
`timescale 1ns/10ps
// Summary of operation
// - Entry copies mode, enable, flag into backups.
// - Entry clears enable and flag; mode per event.
// - Entry saves return address, loads vector.
// - Vector entry is fetched as a jump.
// - Return copies backup bits into status bits.
// - Return loads PC from backup return address.
// - Return clears two low address bits.
// - Backups are undefined after a return.
// - Reset vectors to zero, boot ROM in boot.
// - Peripheral vector, internal RAM in flash mode.
// - Interrupts save next address; reset undefined.
// - Sixteen traps, four-byte spacing, saves address plus four.
// - Unimplemented opcode raises fault, not executed.
// - Synchronous fault beats peripheral interrupt.
// - Faults save own address, half-word bit shown.
// - Undefined and misalign faults have own vectors.
// - Half-word access at odd address faults.
// - Word, lock, unlock at unaligned address fault.
// - Faulting access issues no bus cycle.
// - Emergency break has fixed vector, unmaskable.
module cpu_event_entry_return
  import evt_pkg::*;
#(
  parameter logic [15:0] OP_MAP = 16'hbfff
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Mode straps
  input wire logic BOOT_MODE,
  input wire logic FLASH_EW_MODE,
  // Interrupt sources
  input wire logic BREAK_PIN_N,
  input wire logic PERIPH_IRQ,
  // Instruction in decode
  input wire decode_s DEC,
  input wire logic FLAG_WE,
  input wire logic FLAG_IN,
  // Register port
  input wire reg_req_s REG,
  output logic [31:0] REG_RDATA,
  // Status and fetch control
  output status_word_s STATUS,
  output logic [31:0] BACKUP_RETURN_ADDR,
  output logic REDIRECT,
  output logic [31:0] REDIRECT_PC,
  output logic CANCEL,
  output logic EVENT_TAKEN,
  output event_e EVENT_KIND,
  output logic EVENT_RETURN,
  // Memory request
  output mem_req_s MEM_REQ
);

  typedef struct packed {
    ctl_e ctl;
    logic brk_s1;
    logic brk_s2;
    logic brk_s3;
    logic brk_level;
    logic brk_pend;
    status_word_s status;
    logic [31:0] ret_addr;
    logic redirect;
    logic [31:0] redirect_pc;
    logic cancel;
    logic taken;
    event_e kind;
    logic returned;
    mem_req_s mem;
    logic [31:0] rdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    ctl: CTL_RESET,
    brk_s1: PIN_IDLE,
    brk_s2: PIN_IDLE,
    brk_s3: PIN_IDLE,
    brk_level: PIN_IDLE,
    brk_pend: 1'b0,
    status: STATUS_RESET,
    ret_addr: 32'h0,
    redirect: 1'b0,
    redirect_pc: 32'h0,
    cancel: 1'b0,
    taken: 1'b0,
    kind: EV_RESET,
    returned: 1'b0,
    mem: '{valid: 1'b0, kind: MEM_NONE, addr: 32'h0},
    rdata: 32'h0
  };

  state_s state_r;
  state_s state_nxt;
  logic running;
  logic undef_w;
  logic mis_w;
  logic undef_go;
  logic mis_go;
  logic fault_go;
  logic slot_w;
  logic boundary_w;
  logic brk_fall;
  logic take_brk;
  logic take_irq;
  logic take_trap;
  logic do_return;
  logic take_w;
  logic keep_mode;
  event_e ev_w;
  logic [31:0] vec_w;
  logic [31:0] ret_w;

  fault_check #(
    .OP_MAP(OP_MAP)
  ) u_fault (
    .dec(DEC),
    .undef(undef_w),
    .misalign(mis_w)
  );

  vector_sel u_vec (
    .kind(ev_w),
    .trap_num(DEC.trap_num),
    .boot_mode(BOOT_MODE),
    .flash_ew_mode(FLASH_EW_MODE),
    .vec(vec_w)
  );

  assign running = (state_r.ctl == CTL_RUN);
  assign slot_w = running & DEC.valid;
  assign undef_go = running & undef_w;
  assign mis_go = running & mis_w;
  assign fault_go = undef_go | mis_go;

  // The break edge counts once the two later synchroniser stages agree.
  assign brk_fall = state_r.brk_level & (state_r.brk_s2 == state_r.brk_s3) & ~state_r.brk_s3;

  // Interrupts are taken only in a decode slot on a word boundary, and a fault
  // in the same slot always wins.
  assign boundary_w = slot_w & (DEC.pc[1:0] == 2'b00) & ~fault_go;
  assign take_brk = boundary_w & state_r.brk_pend;
  assign take_irq = boundary_w & ~state_r.brk_pend & PERIPH_IRQ &
                    state_r.status.interrupt_enable_bit;
  assign take_trap = slot_w & ~fault_go & ~take_brk & ~take_irq & DEC.is_trap;
  assign do_return = slot_w & ~fault_go & ~take_brk & ~take_irq & ~DEC.is_trap & DEC.is_return;
  assign take_w = ~running | fault_go | take_brk | take_irq | take_trap;

  assign ev_w = ~running ? EV_RESET :
                undef_go ? EV_UNDEF :
                mis_go ? EV_MISALIGN :
                take_brk ? EV_BREAK :
                take_irq ? EV_PERIPH : EV_TRAP;

  assign keep_mode = (ev_w == EV_UNDEF) | (ev_w == EV_MISALIGN) | (ev_w == EV_TRAP);

  always_comb
  begin
    case (ev_w)
      EV_TRAP:
        ret_w = DEC.pc + TRAP_RET_STEP;
      EV_RESET:
        ret_w = state_r.ret_addr;
      default:
        ret_w = DEC.pc;
    endcase
  end

  always_comb
  begin
    logic [31:0] img;
    img = 32'h0;
    state_nxt = state_r;
    state_nxt.redirect = 1'b0;
    state_nxt.cancel = 1'b0;
    state_nxt.taken = 1'b0;
    state_nxt.returned = 1'b0;
    state_nxt.mem.valid = 1'b0;
    state_nxt.rdata = 32'h0;
    state_nxt.brk_s1 = BREAK_PIN_N;
    state_nxt.brk_s2 = state_r.brk_s1;
    state_nxt.brk_s3 = state_r.brk_s2;
    if (state_r.brk_s2 == state_r.brk_s3)
    begin
      state_nxt.brk_level = state_r.brk_s3;
    end
    // A new edge in the accepting cycle stays pending.
    state_nxt.brk_pend = (state_r.brk_pend & ~take_brk) | brk_fall;
    img[MODE_POS] = state_r.status.stack_mode_bit;
    img[ENABLE_POS] = state_r.status.interrupt_enable_bit;
    img[C_POS] = state_r.status.arith_flag;
    img[SAVED_MODE_POS] = state_r.status.saved_stack_mode;
    img[SAVED_ENABLE_POS] = state_r.status.saved_int_enable;
    img[SAVED_FLAG_POS] = state_r.status.saved_arith_flag;
    if (REG.rd)
    begin
      if (REG.addr == REG_STATUS_OFF)
      begin
        state_nxt.rdata = img;
      end
      else if (REG.addr == REG_RET_ADDR_OFF)
      begin
        state_nxt.rdata = state_r.ret_addr;
      end
    end
    if (REG.wr && REG.addr == REG_STATUS_OFF)
    begin
      state_nxt.status.stack_mode_bit = REG.wdata[MODE_POS];
      state_nxt.status.interrupt_enable_bit = REG.wdata[ENABLE_POS];
      state_nxt.status.arith_flag = REG.wdata[C_POS];
      state_nxt.status.saved_stack_mode = REG.wdata[SAVED_MODE_POS];
      state_nxt.status.saved_int_enable = REG.wdata[SAVED_ENABLE_POS];
      state_nxt.status.saved_arith_flag = REG.wdata[SAVED_FLAG_POS];
    end
    if (REG.wr && REG.addr == REG_RET_ADDR_OFF)
    begin
      state_nxt.ret_addr = REG.wdata;
    end
    if (FLAG_WE)
    begin
      state_nxt.status.arith_flag = FLAG_IN;
    end
    case (state_r.ctl)
      CTL_RESET, CTL_RUN:
      begin
        state_nxt.ctl = CTL_RUN;
        if (take_w)
        begin
          // The whole entry lands in one register update.
          state_nxt.status.saved_stack_mode = state_r.status.stack_mode_bit;
          state_nxt.status.saved_int_enable = state_r.status.interrupt_enable_bit;
          state_nxt.status.saved_arith_flag = state_r.status.arith_flag;
          state_nxt.status.interrupt_enable_bit = 1'b0;
          state_nxt.status.arith_flag = 1'b0;
          state_nxt.status.stack_mode_bit = keep_mode &
                                            state_r.status.stack_mode_bit;
          state_nxt.ret_addr = ret_w;
          // Fetch restarts at the entry, which holds a software jump.
          state_nxt.redirect = 1'b1;
          state_nxt.redirect_pc = vec_w;
          state_nxt.taken = 1'b1;
          state_nxt.kind = ev_w;
          state_nxt.cancel = (ev_w != EV_TRAP) & (ev_w != EV_RESET);
        end
        else if (do_return)
        begin
          // Backups keep stale values; software must not rely on them.
          state_nxt.status.stack_mode_bit = state_r.status.saved_stack_mode;
          state_nxt.status.interrupt_enable_bit = state_r.status.saved_int_enable;
          state_nxt.status.arith_flag = state_r.status.saved_arith_flag;
          state_nxt.redirect = 1'b1;
          state_nxt.redirect_pc = state_r.ret_addr & RET_ALIGN_MASK;
          state_nxt.returned = 1'b1;
        end
        else if (slot_w && DEC.mem_kind != MEM_NONE)
        begin
          // Only non-faulting slots reach here, so a fault issues no access.
          state_nxt.mem.valid = 1'b1;
          state_nxt.mem.kind = DEC.mem_kind;
          state_nxt.mem.addr = DEC.mem_addr;
        end
      end
      default:
        state_nxt.ctl = CTL_RESET;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state_r <= STATE_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign REG_RDATA = state_r.rdata;
  assign STATUS = state_r.status;
  assign BACKUP_RETURN_ADDR = state_r.ret_addr;
  assign REDIRECT = state_r.redirect;
  assign REDIRECT_PC = state_r.redirect_pc;
  assign CANCEL = state_r.cancel;
  assign EVENT_TAKEN = state_r.taken;
  assign EVENT_KIND = state_r.kind;
  assign EVENT_RETURN = state_r.returned;
  assign MEM_REQ = state_r.mem;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_backup_copy: assert property (EVENT_TAKEN && $past(!RESET) |->
    STATUS.saved_int_enable == $past(state_r.status.interrupt_enable_bit) &&
    STATUS.saved_stack_mode == $past(state_r.status.stack_mode_bit) &&
    STATUS.saved_arith_flag == $past(state_r.status.arith_flag))
    else $error("Backup bits do not match status before entry.");

  a_entry_clears: assert property (EVENT_TAKEN |->
    !STATUS.interrupt_enable_bit && !STATUS.arith_flag)
    else $error("Enable or flag not cleared on entry.");

  a_mode_per_event: assert property (EVENT_TAKEN && $past(!RESET) |->
    STATUS.stack_mode_bit == ((EVENT_KIND == EV_UNDEF || EVENT_KIND == EV_MISALIGN ||
    EVENT_KIND == EV_TRAP) && $past(state_r.status.stack_mode_bit)))
    else $error("Stack mode bit wrong after entry.");

  a_trap_return: assert property (slot_w && take_trap |=>
    BACKUP_RETURN_ADDR == $past(DEC.pc) + TRAP_RET_STEP &&
    REDIRECT_PC == VEC_TRAP_BASE + {26'h0, $past(DEC.trap_num), 2'b00})
    else $error("Trap return address or vector wrong.");

  a_fault_wins: assert property (running && fault_go && PERIPH_IRQ |=>
    EVENT_TAKEN && CANCEL && (EVENT_KIND == EV_UNDEF || EVENT_KIND == EV_MISALIGN) &&
    BACKUP_RETURN_ADDR == $past(DEC.pc))
    else $error("Fault not taken ahead of peripheral interrupt.");

  a_no_fault_access: assert property (mis_go |=> !MEM_REQ.valid && CANCEL)
    else $error("Memory access issued for a faulting slot.");

  a_return_align: assert property (do_return |=>
    EVENT_RETURN && REDIRECT && REDIRECT_PC[1:0] == 2'b00 &&
    REDIRECT_PC[31:2] == $past(state_r.ret_addr[31:2]))
    else $error("Return target not word aligned backup address.");

  a_return_status: assert property (EVENT_RETURN |->
    STATUS.interrupt_enable_bit == $past(state_r.status.saved_int_enable) &&
    STATUS.stack_mode_bit == $past(state_r.status.saved_stack_mode) &&
    STATUS.arith_flag == $past(state_r.status.saved_arith_flag))
    else $error("Status bits not restored on return.");

  a_break_vector: assert property (EVENT_TAKEN && EVENT_KIND == EV_BREAK |->
    REDIRECT_PC == VEC_BREAK)
    else $error("Emergency break vector wrong.");

  a_periph_gate: assert property (EVENT_TAKEN && EVENT_KIND == EV_PERIPH |->
    $past(state_r.status.interrupt_enable_bit) &&
    REDIRECT_PC == ($past(FLASH_EW_MODE) ? VEC_FLASH_RAM : VEC_PERIPH))
    else $error("Peripheral interrupt taken while masked or bad vector.");

  a_break_latency: assert property ($fell(state_r.brk_s3) && state_r.brk_level &&
    (state_r.brk_s2 == state_r.brk_s3) |=>
    state_r.brk_pend || (EVENT_TAKEN && EVENT_KIND == EV_BREAK))
    else $error("Break edge not latched.");

endmodule

// ### evt_pkg.sv
package evt_pkg;

  // Vector entries and return-address handling.
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_BOOT = 32'h8000_0000;
  localparam logic [31:0] VEC_BREAK = 32'h0000_0010;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0020;
  localparam logic [31:0] VEC_MISALIGN = 32'h0000_0030;
  localparam logic [31:0] VEC_TRAP_BASE = 32'h0000_0040;
  localparam logic [31:0] VEC_PERIPH = 32'h0000_0080;
  localparam logic [31:0] VEC_FLASH_RAM = 32'h0080_4000;
  localparam logic [31:0] TRAP_RET_STEP = 32'h0000_0004;
  localparam logic [31:0] RET_ALIGN_MASK = 32'hffff_fffc;

  // Register port offsets and status word field positions.
  localparam logic [7:0] REG_STATUS_OFF = 8'h00;
  localparam logic [7:0] REG_RET_ADDR_OFF = 8'h04;
  localparam int MODE_POS = 7;
  localparam int ENABLE_POS = 6;
  localparam int C_POS = 0;
  localparam int SAVED_MODE_POS = 15;
  localparam int SAVED_ENABLE_POS = 14;
  localparam int SAVED_FLAG_POS = 8;

  // Idle level of the break pin and its synchroniser.
  localparam logic PIN_IDLE = 1'b1;

  typedef enum logic [3:0] {
    MEM_NONE = 4'h0,
    LOAD_HALF = 4'h1,
    LOAD_HALF_UNSIGNED = 4'h2,
    WRITE_HALF = 4'h3,
    LOAD_WORD = 4'h4,
    WRITE_WORD = 4'h5,
    LOCK_READ = 4'h6,
    UNLOCK_WRITE = 4'h7,
    LOAD_BYTE = 4'h8,
    WRITE_BYTE = 4'h9
  } mem_kind_e;

  typedef enum logic [2:0] {
    EV_RESET = 3'h0,
    EV_BREAK = 3'h1,
    EV_UNDEF = 3'h2,
    EV_MISALIGN = 3'h3,
    EV_TRAP = 3'h4,
    EV_PERIPH = 3'h5
  } event_e;

  typedef enum logic [1:0] {
    CTL_RESET = 2'b01,
    CTL_RUN = 2'b10
  } ctl_e;

  typedef struct packed {
    logic stack_mode_bit;
    logic interrupt_enable_bit;
    logic arith_flag;
    logic saved_stack_mode;
    logic saved_int_enable;
    logic saved_arith_flag;
  } status_word_s;

  localparam status_word_s STATUS_RESET = '0;

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [15:0] opcode;
    logic is_trap;
    logic [3:0] trap_num;
    logic is_return;
    mem_kind_e mem_kind;
    logic [31:0] mem_addr;
  } decode_s;

  typedef struct packed {
    logic valid;
    mem_kind_e kind;
    logic [31:0] addr;
  } mem_req_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// ### fault_check.sv
`timescale 1ns/10ps
module fault_check
  import evt_pkg::*;
#(
  parameter logic [15:0] OP_MAP = 16'hbfff
)
(
  // Instruction in decode
  input wire decode_s dec,
  // Fault flags
  output logic undef,
  output logic misalign
);

  logic mis_raw;

  // One bit per major opcode; a cleared bit marks an unimplemented opcode.
  assign undef = dec.valid & ~OP_MAP[dec.opcode[15:12]];

  always_comb
  begin
    case (dec.mem_kind)
      LOAD_HALF, LOAD_HALF_UNSIGNED, WRITE_HALF:
        mis_raw = dec.mem_addr[0];
      LOAD_WORD, WRITE_WORD, LOCK_READ, UNLOCK_WRITE:
        mis_raw = |dec.mem_addr[1:0];
      default:
        mis_raw = 1'b0;
    endcase
  end

  assign misalign = dec.valid & ~undef & mis_raw;

endmodule

// ### vector_sel.sv
`timescale 1ns/10ps
module vector_sel
  import evt_pkg::*;
(
  // Event and mode selection
  input wire event_e kind,
  input wire logic [3:0] trap_num,
  input wire logic boot_mode,
  input wire logic flash_ew_mode,
  // Vector entry address
  output logic [31:0] vec
);

  always_comb
  begin
    case (kind)
      EV_RESET:
        vec = boot_mode ? VEC_BOOT : VEC_RESET;
      EV_BREAK:
        vec = VEC_BREAK;
      EV_UNDEF:
        vec = VEC_UNDEF;
      EV_MISALIGN:
        vec = VEC_MISALIGN;
      EV_TRAP:
        vec = VEC_TRAP_BASE + {26'h0, trap_num, 2'b00};
      EV_PERIPH:
        vec = flash_ew_mode ? VEC_FLASH_RAM : VEC_PERIPH;
      default:
        vec = VEC_RESET;
    endcase
  end

endmodule

// ### irq_ctrl_model.sv
`timescale 1ns/10ps
module irq_ctrl_model
  import evt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the bench and acceptance seen at the core
  input wire logic raise,
  input wire logic taken,
  input wire event_e kind,
  // Request level to the core
  output logic irq
);
  // The request is a level that stays up through faults until the core accepts it.
  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else if (raise)
      irq <= 1'b1;
    else if (taken && kind == EV_PERIPH)
      irq <= 1'b0;
  end
endmodule

// ### cpu_event_entry_return_tb_top.sv
`timescale 1ns/10ps
module cpu_event_entry_return_tb_top
  import evt_pkg::*;
();
  logic clk;
  logic rst;
  logic boot;
  logic flash;
  logic brk_n;
  logic raise;
  logic flag_we;
  logic flag_in;
  logic irq;
  decode_s dec;
  reg_req_s req;
  logic [31:0] rdata;
  status_word_s status;
  logic [31:0] ret_addr;
  logic redirect;
  logic [31:0] redirect_pc;
  logic cancel;
  logic ev_taken;
  event_e ev_kind;
  logic ev_ret;
  mem_req_s mem_req;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  cpu_event_entry_return u_dut (
    .CLK(clk), .RESET(rst), .BOOT_MODE(boot), .FLASH_EW_MODE(flash),
    .BREAK_PIN_N(brk_n), .PERIPH_IRQ(irq), .DEC(dec), .FLAG_WE(flag_we),
    .FLAG_IN(flag_in), .REG(req), .REG_RDATA(rdata), .STATUS(status),
    .BACKUP_RETURN_ADDR(ret_addr), .REDIRECT(redirect), .REDIRECT_PC(redirect_pc),
    .CANCEL(cancel), .EVENT_TAKEN(ev_taken), .EVENT_KIND(ev_kind),
    .EVENT_RETURN(ev_ret), .MEM_REQ(mem_req)
  );

  irq_ctrl_model u_irq (
    .clk(clk), .rst(rst), .raise(raise), .taken(ev_taken), .kind(ev_kind), .irq(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // A hung run is cut short well above the few hundred cycles the tests need.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic decode_s mk(input logic [31:0] pc, input logic [15:0] op,
    input logic trap, input logic [3:0] n, input logic return_from_event, input mem_kind_e k,
    input logic [31:0] a);
    mk = '{1'b1, pc, op, trap, n, return_from_event, k, a};
  endfunction

  // One decode slot, then outputs are sampled in the cycle of the answer.
  task automatic slot(input decode_s d);
    @(posedge clk);
    dec <= d;
    @(posedge clk);
    dec <= '0;
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic entry(input event_e k, input logic [31:0] pc, input logic [31:0] bk,
    input logic cn);
    chk(redirect, 1'b1);
    chk(ev_taken, 1'b1);
    chk(ev_kind, k);
    chk(redirect_pc, pc);
    chk(ret_addr, bk);
    chk(cancel, cn);
  endtask

  task automatic do_reset(input logic b);
    rst <= 1'b1;
    boot <= b;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(status, STATUS_RESET);
    for (int i = 0; i < 3 && redirect !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(redirect, 1'b1);
    chk(redirect_pc, b ? VEC_BOOT : VEC_RESET);
    chk(ev_kind, EV_RESET);
  endtask

  task automatic traps();
    logic [31:0] pc;
    reg_wr(REG_STATUS_OFF, 32'h0000_00c0);
    @(posedge clk);
    flag_we <= 1'b1;
    flag_in <= 1'b1;
    @(posedge clk);
    flag_we <= 1'b0;
    for (int n = 0; n < 16; n++)
    begin
      pc = 32'h100 + 2 * n;
      slot(mk(pc, 16'h0, 1'b1, n[3:0], 1'b0, MEM_NONE, 32'h0));
      entry(EV_TRAP, VEC_TRAP_BASE + 4 * n, pc + TRAP_RET_STEP, 1'b0);
      chk(status, 6'b100111);
      slot(mk(pc, 16'h0, 1'b0, 4'h0, 1'b1, MEM_NONE, 32'h0));
      chk(ev_ret, 1'b1);
      chk(redirect_pc, (pc + 4) & RET_ALIGN_MASK);
      chk(status[5:3], 3'b111);
    end
  endtask

  task automatic regs();
    logic [31:0] d;
    reg_wr(REG_STATUS_OFF, 32'h0000_c1c1);
    reg_rd(REG_STATUS_OFF, d);
    chk(d, 32'h0000_c1c1);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0);
    reg_wr(REG_RET_ADDR_OFF, 32'h0000_1236);
    reg_rd(REG_RET_ADDR_OFF, d);
    chk(d, 32'h0000_1236);
    reg_rd(8'h08, d);
    chk(d, 32'h0);
    slot(mk(32'h40, 16'h0, 1'b0, 4'h0, 1'b1, MEM_NONE, 32'h0));
    chk(redirect_pc, 32'h0000_1234);
    chk(status[5:3], 3'b111);
  endtask

  // A masked request waits; an undefined opcode beats it; the return re-enables it.
  task automatic irq_pass(input logic f);
    @(posedge clk);
    flash <= f;
    reg_wr(REG_STATUS_OFF, 32'h0);
    @(posedge clk);
    raise <= 1'b1;
    @(posedge clk);
    raise <= 1'b0;
    slot(mk(32'h4, 16'h0, 1'b0, 4'h0, 1'b0, MEM_NONE, 32'h0));
    chk(redirect, 1'b0);
    reg_wr(REG_STATUS_OFF, 32'h0000_00c0);
    slot(mk(32'h4, 16'he000, 1'b0, 4'h0, 1'b0, MEM_NONE, 32'h0));
    entry(EV_UNDEF, VEC_UNDEF, 32'h4, 1'b1);
    chk(ret_addr[1], 1'b0);
    slot(mk(32'h20, 16'h0, 1'b0, 4'h0, 1'b1, MEM_NONE, 32'h0));
    chk(redirect_pc, 32'h4);
    slot(mk(32'ha, 16'h0, 1'b0, 4'h0, 1'b0, MEM_NONE, 32'h0));
    chk(redirect, 1'b0);
    slot(mk(32'h8, 16'h0, 1'b0, 4'h0, 1'b0, MEM_NONE, 32'h0));
    entry(EV_PERIPH, f ? VEC_FLASH_RAM : VEC_PERIPH, 32'h8, 1'b1);
    chk(status[5:4], 2'b00);
  endtask

  task automatic misalign();
    logic bad;
    for (int k = 1; k < 10; k++)
      for (int a = 0; a < 4; a++)
      begin
        bad = (k < 4) ? a[0] : ((k < 8) ? (a != 0) : 1'b0);
        slot(mk(32'h302, 16'h0, 1'b0, 4'h0, 1'b0, mem_kind_e'(k), 32'h200 + a));
        chk(mem_req.valid, !bad);
        chk(redirect, bad);
        if (bad)
          entry(EV_MISALIGN, VEC_MISALIGN, 32'h302, 1'b1);
        else
        begin
          chk(mem_req.addr, 32'h200 + a);
          chk(mem_req.kind, k);
        end
      end
  endtask

  // The break is taken with the enable bit clear, on a word boundary only.
  task automatic brk();
    reg_wr(REG_STATUS_OFF, 32'h0000_0080);
    @(posedge clk);
    brk_n <= 1'b0;
    repeat (5) @(posedge clk);
    brk_n <= 1'b1;
    slot(mk(32'h22, 16'h0, 1'b0, 4'h0, 1'b0, MEM_NONE, 32'h0));
    chk(redirect, 1'b0);
    slot(mk(32'h24, 16'h0, 1'b0, 4'h0, 1'b0, MEM_NONE, 32'h0));
    entry(EV_BREAK, VEC_BREAK, 32'h24, 1'b1);
    chk(status[2], 1'b1);
    chk(status[5:4], 2'b00);
  endtask

  initial
  begin
    rst = 1'b1;
    boot = 1'b0;
    flash = 1'b0;
    brk_n = 1'b1;
    raise = 1'b0;
    flag_we = 1'b0;
    flag_in = 1'b0;
    dec = '0;
    req = '0;
    do_reset(1'b0);
    traps();
    regs();
    irq_pass(1'b0);
    irq_pass(1'b1);
    misalign();
    brk();
    @(posedge clk);
    do_reset(1'b1);
    report_and_stop();
  end
endmodule
